// [vphy_field_reg.v]
// Holds one resettable register field with write enable.
// Assumes a single clock, asynchronous active-low reset and a clock enable.
module vphy_field_reg #(
    parameter W = 16,
    parameter [W-1:0] RST = {W{1'b0}}
) (
    // Clock and reset
    input wire clk,
    input wire arst_n,
    input wire ce,
    // Write
    input wire we,
    input wire [W-1:0] d,
    // Value
    output reg [W-1:0] q
);

always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
        q <= RST;
    end else if (ce && we) begin
        q <= d;
    end
end

endmodule // vphy_field_reg

// [vphy_id_adv_consts.vh]
// Constants for the emulated PHY identifier and advertisement registers.
// Included by bare name; holds definitions only.
`ifndef VPHY_ID_ADV_CONSTS_VH
`define VPHY_ID_ADV_CONSTS_VH

// Host byte offsets
`define OFS_ID_HIGH 9'h1c8
`define OFS_ID_LOW 9'h1cc
`define OFS_ADV 9'h1d0
// Host window base (index 0) and window tag bits [8:5]
`define HOST_WIN_TAG 4'he
// Register indices, shared by host and serial management
`define IDX_ID_HIGH 5'h02
`define IDX_ID_LOW 5'h03
`define IDX_ADV 5'h04
// Field positions, low identifier
`define OUI_LO_MSB 15
`define OUI_LO_LSB 10
`define MODEL_MSB 9
`define MODEL_LSB 4
`define REV_MSB 3
`define REV_LSB 0
// Reset values
`define RST_ID_HIGH 16'h0000
`define RST_OUI_LO 6'h00
`define RST_MODEL 6'h00
`define RST_REV 4'h0
`define RST_ADV 16'h0000
// Reserved padding read value
`define PAD_ZERO 16'h0000

`endif

// [vphy_id_adv_regs.v]
// Emulated PHY identifier (high, low) and advertisement registers.
// Host reaches them as 32-bit words by byte offset, serial management
// as 16-bit words by index; the loader rewrites the advertisement word.
`include "vphy_id_adv_consts.vh"

// Operation
// - Bits 31:16 of the low identifier word are read-only padding.
// - Over serial management the identifier reads and writes as a 16-bit register.
// - Low identifier bits 15:10 hold the low six OUI bits, read/write, reset zero.
// - Low identifier bits 9:4 hold a six-bit model number, read/write, reset zero.
// - Low identifier bits 3:0 hold a four-bit revision, read/write, reset zero.
// - Any identifier bit may be zero; an all-zero identifier is kept as is.
// - The loader overwrites the whole advertisement word, winning over software.
// - The advertisement register is read/write and drives the offered abilities.
// - The high identifier holds the upper sixteen bits, read/write, reset zero.
module vphy_id_adv_regs #(
    parameter ADV_W = 16
) (
    // Clock, reset, enable
    input wire I_MCLK,
    input wire I_ARST_N,
    input wire I_CE,
    // Host word access
    input wire [8:0] I_HOST_ADDR,
    input wire I_HOST_WR,
    input wire I_HOST_RD,
    input wire [31:0] I_HOST_WDATA,
    output reg [31:0] O_HOST_RDATA,
    output reg O_HOST_RVALID,
    // Serial management access
    input wire [4:0] I_MII_REGIDX,
    input wire I_MII_WR,
    input wire I_MII_RD,
    input wire [15:0] I_MII_WDATA,
    output reg [15:0] O_MII_RDATA,
    output reg O_MII_RVALID,
    // Configuration loader
    input wire I_LOAD_WR,
    input wire [ADV_W-1:0] I_LOAD_DATA,
    // Offered abilities
    output wire [ADV_W-1:0] O_ADV_ABILITY
);

////////////////////////////////////////////////////////////////////////////////
// Decode

// One-hot select: bit0 id high, bit1 id low, bit2 advertisement
function [2:0] idx_sel;
    input [4:0] idx;
    begin
        case (idx)
            `IDX_ID_HIGH: idx_sel = 3'h1;
            `IDX_ID_LOW: idx_sel = 3'h2;
            `IDX_ADV: idx_sel = 3'h4;
            default: idx_sel = 3'h0;
        endcase
    end
endfunction

// Host window: tag bits match and word aligned
wire host_tag_hit;
wire host_aligned;
wire host_in_win;
wire [4:0] host_idx;
wire [2:0] host_sel;
wire [2:0] mii_sel;

assign host_tag_hit = (I_HOST_ADDR[8:5] == `HOST_WIN_TAG);
assign host_aligned = (I_HOST_ADDR[1:0] == 2'h0);
assign host_in_win = host_tag_hit && host_aligned;
assign host_idx = {2'h0, I_HOST_ADDR[4:2]};
assign host_sel = host_in_win ? idx_sel(host_idx) : 3'h0;
assign mii_sel = idx_sel(I_MII_REGIDX);

////////////////////////////////////////////////////////////////////////////////
// Registers

wire [15:0] id_high_q;
wire [15:0] id_low_q;
wire [ADV_W-1:0] adv_q;
reg [2:0] wr_en;
reg [15:0] wr_data;
reg [ADV_W-1:0] adv_data;

////////////////////////////////////////////////////////////////////////////////
// Write strobes

wire host_wr_hit;
wire mii_wr_hit;
wire adv_we;

assign host_wr_hit = I_HOST_WR && (host_sel != 3'h0);
assign mii_wr_hit = I_MII_WR && (mii_sel != 3'h0);

// Host write wins over a simultaneous serial write; only low half kept
always @* begin
    wr_en = 3'h0;
    wr_data = I_MII_WDATA;
    if (host_wr_hit) begin
        wr_en = host_sel;
        wr_data = I_HOST_WDATA[15:0];
    end else if (mii_wr_hit) begin
        wr_en = mii_sel;
    end
end

// Loader overwrite takes priority over any software write
always @* begin
    adv_data = wr_data[ADV_W-1:0];
    if (I_LOAD_WR) begin
        adv_data = I_LOAD_DATA;
    end
end

assign adv_we = wr_en[2] | I_LOAD_WR;

vphy_field_reg #(.W(16), .RST(`RST_ID_HIGH)) u_id_high (
    .clk(I_MCLK),
    .arst_n(I_ARST_N),
    .ce(I_CE),
    .we(wr_en[0]),
    .d(wr_data),
    .q(id_high_q)
);

vphy_field_reg #(.W(16), .RST({`RST_OUI_LO, `RST_MODEL, `RST_REV})) u_id_low (
    .clk(I_MCLK),
    .arst_n(I_ARST_N),
    .ce(I_CE),
    .we(wr_en[1]),
    .d(wr_data),
    .q(id_low_q)
);

vphy_field_reg #(.W(ADV_W), .RST(`RST_ADV)) u_adv (
    .clk(I_MCLK),
    .arst_n(I_ARST_N),
    .ce(I_CE),
    .we(adv_we),
    .d(adv_data),
    .q(adv_q)
);

assign O_ADV_ABILITY = adv_q;

////////////////////////////////////////////////////////////////////////////////
// Read mux

function [15:0] rd_mux;
    input [2:0] sel;
    input [15:0] hi;
    input [15:0] lo;
    input [15:0] adv;
    begin
        case (sel)
            3'h1: rd_mux = hi;
            3'h2: rd_mux = lo;
            3'h4: rd_mux = adv;
            default: rd_mux = 16'h0000;
        endcase
    end
endfunction

// Advertisement word widened to the read path
wire [15:0] adv_ext;

generate
    if (ADV_W < 16) begin : g_adv_pad
        assign adv_ext = {{(16-ADV_W){1'b0}}, adv_q};
    end else begin : g_adv_full
        assign adv_ext = adv_q[15:0];
    end
endgenerate

wire [5:0] oui_low_f;
wire [5:0] model_f;
wire [3:0] rev_f;
wire [15:0] id_low_view;

assign oui_low_f = id_low_q[`OUI_LO_MSB:`OUI_LO_LSB];
assign model_f = id_low_q[`MODEL_MSB:`MODEL_LSB];
assign rev_f = id_low_q[`REV_MSB:`REV_LSB];
assign id_low_view = {oui_low_f, model_f, rev_f};

reg [31:0] host_rdata_nxt;
reg host_rvalid_nxt;
reg [15:0] mii_rdata_nxt;
reg mii_rvalid_nxt;

// Read data holds until the next read of the same port
always @* begin
    host_rvalid_nxt = I_HOST_RD;
    host_rdata_nxt = O_HOST_RDATA;
    if (I_HOST_RD) begin
        host_rdata_nxt = {`PAD_ZERO, rd_mux(host_sel, id_high_q, id_low_view, adv_ext)};
    end
end

always @* begin
    mii_rvalid_nxt = I_MII_RD;
    mii_rdata_nxt = O_MII_RDATA;
    if (I_MII_RD) begin
        mii_rdata_nxt = rd_mux(mii_sel, id_high_q, id_low_view, adv_ext);
    end
end

always @(posedge I_MCLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
        O_HOST_RDATA <= 32'h00000000;
        O_HOST_RVALID <= 1'b0;
    end else if (I_CE) begin
        O_HOST_RDATA <= host_rdata_nxt;
        O_HOST_RVALID <= host_rvalid_nxt;
    end
end

always @(posedge I_MCLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
        O_MII_RDATA <= 16'h0000;
        O_MII_RVALID <= 1'b0;
    end else if (I_CE) begin
        O_MII_RDATA <= mii_rdata_nxt;
        O_MII_RVALID <= mii_rvalid_nxt;
    end
end

endmodule // vphy_id_adv_regs

// [vphy_id_adv_regs_checker.sv]
// Checker for the emulated PHY id and advertisement registers.
// Sees only top ports; bound below.
module vphy_id_adv_regs_checker(
    input wire I_MCLK, I_ARST_N, I_CE, I_HOST_RD, I_MII_RD, I_LOAD_WR,
    input wire [15:0] I_LOAD_DATA, O_ADV_ABILITY,
    input wire [31:0] O_HOST_RDATA,
    input wire O_HOST_RVALID, O_MII_RVALID);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge I_MCLK); endclocking
    default disable iff (!I_ARST_N);
    AST_PAD: assert property (O_HOST_RVALID |-> O_HOST_RDATA[31:16] == 16'h0)
        else $error("padding not zero");
    AST_HRV: assert property (I_CE && I_HOST_RD |=> O_HOST_RVALID)
        else $error("host read not answered");
    AST_HNV: assert property (I_CE && !I_HOST_RD |=> !O_HOST_RVALID)
        else $error("spurious host valid");
    AST_MRV: assert property (I_CE && I_MII_RD |=> O_MII_RVALID)
        else $error("mgmt read not answered");
    AST_MNV: assert property (I_CE && !I_MII_RD |=> !O_MII_RVALID)
        else $error("spurious mgmt valid");
    AST_LOAD: assert property (I_CE && I_LOAD_WR |=> O_ADV_ABILITY == $past(I_LOAD_DATA))
        else $error("loader value lost");
    AST_FRZ: assert property (!I_CE |=> $stable(O_ADV_ABILITY))
        else $error("abilities moved while frozen");
    AST_RST: assert property ($rose(I_ARST_N) |-> O_ADV_ABILITY == 16'h0)
        else $error("abilities not reset");
endmodule // vphy_id_adv_regs_checker
////////////////////////////////////////////////////////////////////////
bind vphy_id_adv_regs vphy_id_adv_regs_checker vphy_id_adv_regs_checker_i(.I_MCLK, .I_ARST_N,
    .I_CE, .I_HOST_RD, .I_MII_RD, .I_LOAD_WR, .I_LOAD_DATA, .O_ADV_ABILITY, .O_HOST_RDATA,
    .O_HOST_RVALID, .O_MII_RVALID);

// [vphy_id_adv_regs_tb.sv]
// Testbench for the emulated PHY id and advertisement registers.
// Assumes the bound checker and the management model.
module vphy_id_adv_regs_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0, rst_n = 0, hw = 0, hr = 0, lw = 0, ce = 1, v, mqv;
    logic [8:0] ha = 9'h0;
    logic [31:0] hd = 32'h0, q;
    logic [15:0] ld = 16'h0, mq;
    wire [31:0] hq;
    wire [15:0] mrd, adv, mwd;
    wire [4:0] mi;
    wire mw, mr, hv, mrv;
    int n_errors = 0, n_compared = 0;
    always #2.5 clk = ~clk;
    vphy_id_adv_regs vphy_id_adv_regs_i(.I_MCLK(clk), .I_ARST_N(rst_n), .I_CE(ce),
        .I_HOST_ADDR(ha), .I_HOST_WR(hw), .I_HOST_RD(hr), .I_HOST_WDATA(hd),
        .O_HOST_RDATA(hq), .O_HOST_RVALID(hv), .I_MII_REGIDX(mi), .I_MII_WR(mw),
        .I_MII_RD(mr), .I_MII_WDATA(mwd), .O_MII_RDATA(mrd), .O_MII_RVALID(mrv),
        .I_LOAD_WR(lw), .I_LOAD_DATA(ld), .O_ADV_ABILITY(adv));
    vphy_mgmt_model vphy_mgmt_model_i(.clk(clk), .rdata(mrd), .rvalid(mrv), .idx(mi),
        .wr(mw), .rd(mr), .wd(mwd));
    ////////////////////////////////////////////////////////////////////
    task chk(input [31:0] g, input [31:0] e);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task h(input w, input [8:0] a, input [31:0] d);
        ha = a;
        hd = d;
        hw = w;
        hr = !w;
        @(posedge clk);
        #1 q = hq;
        v = hv;
        {hw, hr} = 2'h0;
        hd = ~d;
        @(posedge clk);
        #1;
    endtask
    task report_and_stop;
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    task t_reset;
        for (int i = 0; i < 3; i++) begin
            h(0, 9'(9'h1c8 + 4 * i), 0);
            chk(q, 0);
            chk(v, 1);
        end
    endtask
    task t_idlow;
        h(1, 9'h1cc, 32'hffff_a5c3);
        chk(v, 0);
        h(0, 9'h1cc, 0);
        chk(q, 32'h0000_a5c3);
        vphy_mgmt_model_i.m(0, 5'h03, 0, mq, mqv);
        chk(mq, 16'ha5c3);
        chk(mqv, 1);
        h(1, 9'h1cc, 0);
        h(0, 9'h1cc, 0);
        chk(q, 0);
    endtask
    task t_mgmt;
        vphy_mgmt_model_i.m(1, 5'h02, 16'h1234, mq, mqv);
        chk(mqv, 0);
        h(0, 9'h1c8, 0);
        chk(q, 32'h1234);
    endtask
    task t_adv;
        h(1, 9'h1d0, 32'h5a5a);
        chk(adv, 16'h5a5a);
        ld = 16'h0f0f;
        lw = 1;
        fork
            h(1, 9'h1d0, 32'hffff);
            begin
                @(posedge clk);
                #1 lw = 0;
            end
        join
        chk(adv, 16'h0f0f);
    endtask
    task t_freeze;
        ce = 0;
        h(1, 9'h1d0, 32'h3c3c);
        chk(adv, 16'h0f0f);
        h(0, 9'h1d0, 0);
        chk(v, 0);
        ce = 1;
        h(0, 9'h1d0, 0);
        chk(q, 32'h0f0f);
    endtask
    task t_rerun;
        h(1, 9'h1cc, 32'h0000_fc1f);
        rst_n = 0;
        repeat (2) @(posedge clk);
        #1 rst_n = 1;
        chk(adv, 0);
        t_reset;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        #1 rst_n = 1;
        t_reset;
        t_idlow;
        t_mgmt;
        t_adv;
        t_freeze;
        t_rerun;
        report_and_stop;
    end
    initial begin
        #2000;
        n_errors++;
        report_and_stop;
    end
endmodule // vphy_id_adv_regs_tb

// [vphy_mgmt_model.sv]
// Management master model: one 16-bit access per call.
// Assumes one clock; caller enters just after an edge.
module vphy_mgmt_model(
    input wire clk,
    input wire [15:0] rdata,
    input wire rvalid,
    output logic [4:0] idx = 5'h0,
    output logic wr = 1'b0,
    output logic rd = 1'b0,
    output logic [15:0] wd = 16'h0);
    timeunit 1ns;
    timeprecision 100ps;
    task m(input w, input [4:0] i, input [15:0] d, output [15:0] q, output v);
        idx = i;
        wd = d;
        wr = w;
        rd = !w;
        @(posedge clk);
        #1 q = rdata;
        v = rvalid;
        {wr, rd} = 2'h0;
        wd = ~d;
        @(posedge clk);
        #1;
    endtask
endmodule // vphy_mgmt_model
